// *** hdl/swc_pkg.sv ***
// constants, field layout and types for the sleep and wake controller
// assumes a 50 MHz system clock that keeps running while the core sleeps
//
// What this block does
// - sleep with watchdog enabled clears its count; watchdog keeps running
// - entering sleep clears power-down flag and sets time-out flag
// - entering sleep turns the main oscillator driver off
// - in sleep every port holds its previous drive state
// - watchdog reset is internal and never pulls the reset pin
// - wake on reset pin, enabled watchdog expiry or enabled interrupt
// - reset pin wake resets fully; watchdog and interrupt wakes resume
// - power-down flag set at power-up; time-out flag cleared on watchdog wake
// - sleep-capable sources: timer one, capture, A/D, EEPROM, comparator, change, pin, serial, I2C slave
// - clock-dependent peripherals raise no interrupt while asleep
// - sleep prefetches the instruction at the next address
// - a source wakes only when individually enabled; global enable irrelevant
// - after interrupt wake run next instruction, then vector if global enable
// - watchdog cleared on every watchdog or interrupt wake
// - enabled interrupt pending before sleep makes sleep a no-operation
// - interrupt during sleep: sleep completes with all effects, then wakes
// - fuse enable forces watchdog on, otherwise the soft enable bit rules
package swc_pkg;
    // apb map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WAKE_EN = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    // control register fields
    localparam int CTRL_SOFT_EN_BIT = 0;
    localparam int CTRL_PS_LSB = 1;
    localparam int CTRL_PS_W = 4;
    localparam logic [4:0] CTRL_RESET = 5'h08;
    localparam logic [3:0] PS_MAX = 4'hB;
    // status register fields
    localparam int STAT_PD_BIT = 0;
    localparam int STAT_TO_BIT = 1;
    localparam int STAT_WDT_ON_BIT = 2;
    localparam int STAT_STATE_LSB = 3;
    // sleep-capable wake sources
    localparam int NUM_SRC = 9;
    localparam int SRC_TIMER_ONE = 0;
    localparam int SRC_CAPTURE = 1;
    localparam int SRC_ADC_RC = 2;
    localparam int SRC_EEPROM = 3;
    localparam int SRC_COMPARATOR = 4;
    localparam int SRC_PORT_CHANGE = 5;
    localparam int SRC_EXT_PIN = 6;
    localparam int SRC_SERIAL_BREAK = 7;
    localparam int SRC_I2C_SLAVE = 8;
    localparam logic [NUM_SRC-1:0] WAKE_EN_RESET = 9'h000;
    // interrupt vector the core branches to
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    // timing
    localparam int CLK_HZ = 50000000;
    localparam int WDT_OSC_HZ = 31000;
    localparam int WDT_TICK_CYCLES = CLK_HZ / WDT_OSC_HZ;
    localparam int WDT_BASE_DIV = 32;
    localparam int OSC_START_NS = 1000;
    localparam int OSC_START_CYCLES = (OSC_START_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int SYNC_W = 3;
    localparam int PIN_RESET_N = 0;
    localparam int PIN_EXT_IRQ = 1;
    localparam int PIN_OSC_OK = 2;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} swc_state_e;
endpackage

// *** hdl/swc_pin_if.sv ***
// raw and filtered pin levels between the controller and its synchroniser
// assumes all pins are asynchronous to clk_sys
`timescale 1ns/1ps
interface swc_pin_if;
    import swc_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] stable;
    modport filt (input raw, output stable);
    modport user (output raw, input stable);
endinterface

// *** hdl/swc_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
// assumes raw pins are asynchronous; reset value given by RESET_VAL
`timescale 1ns/1ps
module swc_pin_sync
    import swc_pkg::*;
#(
    parameter logic [SYNC_W-1:0] RESET_VAL = 3'h0
)
(
    input wire logic clk_sys, // system clock
    input wire logic rst, // synchronous reset, high
    swc_pin_if.filt pins // raw in, stable out
);
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] s3_q;
    logic [SYNC_W-1:0] stable_q;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end
        else
        begin
            s1_q <= pins.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a level counts once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            stable_q <= RESET_VAL;
        else
        begin
            for (int i = 0; i < SYNC_W; i++)
            begin
                if (s2_q[i] == s3_q[i])
                    stable_q[i] <= s3_q[i];
            end
        end
    end

    assign pins.stable = stable_q;
endmodule

// *** hdl/swc_sleep_wake_control.sv ***
// sleep entry, wake decision, watchdog and status flags with apb registers
// assumes clk_sys is the always-on sleep clock; core and sources share it
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module swc_sleep_wake_control
    import swc_pkg::*;
#(
    parameter int WdtTickCycles = WDT_TICK_CYCLES
)
(
    input wire logic clk_sys, // system clock
    input wire logic rst, // power-up reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic sleepOp, // core executes sleep, one cycle
    input wire logic watchdogClearOp, // core executes watchdog clear
    input wire logic globalIrqEnable, // core global enable
    input wire logic watchdogFuseEnable, // configuration fuse
    input wire logic [NUM_SRC-1:0] srcFlags, // sleep-capable source flags
    input wire logic clockedIrqPending, // enabled clock-dependent irq
    input wire logic externalResetPinN, // reset pin, low active
    input wire logic externalIrqPin, // external interrupt pin
    input wire logic oscValid, // oscillator reports stable
    output logic oscDriverEn_q, // main oscillator driver on
    output logic ioHold_q, // ports freeze drive state
    output logic coreHold_q, // core execution held
    output logic prefetchNext_q, // fetch next address, pulse
    output logic sleepNop_q, // sleep behaved as no-op, pulse
    output logic resumeNext_q, // resume at prefetched op, pulse
    output logic vectorAfterNext_q, // branch to vector after next op
    output logic wdtResetReq_q, // internal watchdog reset, pulse
    output logic fullResetReq_q, // device reset from pin
    output logic powerDownFlagN_q, // power-down flag, low active
    output logic timeOutFlagN_q // time-out flag, low active
);
    swc_state_e state_q;
    logic [4:0] ctrl_q;
    logic [NUM_SRC-1:0] wakeEn_q;
    logic [16:0] wdtCnt_q;
    logic [15:0] tickCnt_q;
    logic [7:0] oscWait_q;
    logic [16:0] wdtLimit;
    logic [3:0] psSel;
    logic wdtEnable;
    logic wdtTick;
    logic wdtExpire;
    logic [NUM_SRC-1:0] flags;
    logic irqWake;
    logic wakeReq;
    logic pendingAwake;
    logic resetActive;
    logic oscOk;
    logic sleepTake;
    logic sleepNopNow;
    logic wdtClear;
    logic apbAccess;
    logic apbWrite;

    swc_pin_if pinBus();

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    assign pinBus.raw = {oscValid, externalIrqPin, externalResetPinN};

    swc_pin_sync #(
        .RESET_VAL(3'h1)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pins(pinBus.filt)
    );

    assign resetActive = !pinBus.stable[PIN_RESET_N];
    assign oscOk = pinBus.stable[PIN_OSC_OK];

    ////////////////////////////////////////////////////////////////
    // wake request, needs no state
    always_comb
    begin
        flags = srcFlags;
        flags[SRC_EXT_PIN] = srcFlags[SRC_EXT_PIN] | pinBus.stable[PIN_EXT_IRQ];
    end

    assign irqWake = |(flags & wakeEn_q);
    assign wakeReq = irqWake | wdtExpire;
    // clocked peripherals only count while awake
    assign pendingAwake = irqWake | clockedIrqPending;
    assign sleepTake = state_q == ST_RUN && sleepOp && !pendingAwake && !resetActive;
    assign sleepNopNow = state_q == ST_RUN && sleepOp && pendingAwake;

    ////////////////////////////////////////////////////////////////
    // watchdog
    assign wdtEnable = watchdogFuseEnable | ctrl_q[CTRL_SOFT_EN_BIT];
    assign psSel = (ctrl_q[CTRL_PS_LSB +: CTRL_PS_W] > PS_MAX) ? PS_MAX
                   : ctrl_q[CTRL_PS_LSB +: CTRL_PS_W];
    assign wdtLimit = (17'(WDT_BASE_DIV) << psSel) - 17'h00001;
    assign wdtTick = tickCnt_q == 16'(WdtTickCycles - 1);
    assign wdtExpire = wdtEnable && wdtTick && wdtCnt_q == wdtLimit;
    // cleared on sleep entry, watchdog or interrupt wake, clear op, expiry
    assign wdtClear = sleepTake || watchdogClearOp || !wdtEnable || wdtExpire
                      || (state_q == ST_SLEEP && wakeReq);

    always_ff @(posedge clk_sys)
    begin
        if (rst || wdtClear)
            tickCnt_q <= 16'h0000;
        else if (wdtTick)
            tickCnt_q <= 16'h0000;
        else
            tickCnt_q <= tickCnt_q + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || wdtClear)
            wdtCnt_q <= 17'h00000;
        else if (wdtTick)
            wdtCnt_q <= wdtCnt_q + 17'h00001;
    end

    ////////////////////////////////////////////////////////////////
    // sleep state machine
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_q <= ST_RUN;
        else
        begin
            case (state_q)
                ST_RUN:
                    if (sleepTake)
                        state_q <= ST_SLEEP;
                ST_SLEEP:
                    if (resetActive)
                        state_q <= ST_RUN;
                    else if (wakeReq)
                        state_q <= ST_WAKE;
                ST_WAKE:
                    if (resetActive)
                        state_q <= ST_RUN;
                    else if (oscOk && oscWait_q == 8'(OSC_START_CYCLES))
                        state_q <= ST_RUN;
                default:
                    state_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || state_q != ST_WAKE)
            oscWait_q <= 8'h00;
        else if (oscWait_q != 8'(OSC_START_CYCLES))
            oscWait_q <= oscWait_q + 8'h01;
    end

    ////////////////////////////////////////////////////////////////
    // core-facing controls
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            oscDriverEn_q <= 1'b1;
            ioHold_q <= 1'b0;
            coreHold_q <= 1'b0;
        end
        else if (sleepTake)
        begin
            oscDriverEn_q <= 1'b0;
            ioHold_q <= 1'b1;
            coreHold_q <= 1'b1;
        end
        else if (state_q != ST_RUN && resetActive)
        begin
            oscDriverEn_q <= 1'b1;
            ioHold_q <= 1'b0;
            coreHold_q <= 1'b0;
        end
        else if (state_q == ST_SLEEP && wakeReq)
            oscDriverEn_q <= 1'b1;
        else if (state_q == ST_WAKE && oscOk && oscWait_q == 8'(OSC_START_CYCLES))
        begin
            ioHold_q <= 1'b0;
            coreHold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            prefetchNext_q <= 1'b0;
            sleepNop_q <= 1'b0;
            resumeNext_q <= 1'b0;
        end
        else
        begin
            prefetchNext_q <= sleepTake || sleepNopNow;
            sleepNop_q <= sleepNopNow;
            resumeNext_q <= state_q == ST_WAKE && !resetActive && oscOk
                            && oscWait_q == 8'(OSC_START_CYCLES);
        end
    end

    // vector choice taken at the wake moment
    always_ff @(posedge clk_sys)
    begin
        if (rst || resetActive)
            vectorAfterNext_q <= 1'b0;
        else if (state_q == ST_SLEEP && wakeReq)
            vectorAfterNext_q <= irqWake && !wdtExpire && globalIrqEnable;
        else if (resumeNext_q)
            vectorAfterNext_q <= 1'b0;
    end

    // watchdog reset is internal only, the pin is never driven
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            wdtResetReq_q <= 1'b0;
        else
            wdtResetReq_q <= wdtExpire && state_q == ST_RUN;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            fullResetReq_q <= 1'b0;
        else
            fullResetReq_q <= resetActive;
    end

    ////////////////////////////////////////////////////////////////
    // status flags
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            powerDownFlagN_q <= 1'b1;
            timeOutFlagN_q <= 1'b1;
        end
        else if (sleepTake)
        begin
            powerDownFlagN_q <= 1'b0;
            timeOutFlagN_q <= 1'b1;
        end
        else if (wdtExpire && state_q != ST_WAKE)
        begin
            timeOutFlagN_q <= 1'b0;
            if (state_q == ST_RUN)
                powerDownFlagN_q <= 1'b1;
        end
        else if (watchdogClearOp && state_q == ST_RUN)
        begin
            powerDownFlagN_q <= 1'b1;
            timeOutFlagN_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // apb slave, one wait state
    assign apbAccess = psel && penable && pready;
    assign apbWrite = apbAccess && pwrite && !pslverr;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && penable && !pready)
            begin
                case (paddr)
                    ADDR_CTRL:
                        prdata <= {27'h0000000, ctrl_q};
                    ADDR_WAKE_EN:
                        prdata <= {23'h000000, wakeEn_q};
                    ADDR_STATUS:
                        prdata <= {27'h0000000, state_q, wdtEnable,
                                   timeOutFlagN_q, powerDownFlagN_q};
                    ADDR_FLAGS:
                        prdata <= {23'h000000, flags};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RESET;
            wakeEn_q <= WAKE_EN_RESET;
        end
        else if (apbWrite && paddr == ADDR_CTRL)
            ctrl_q <= pwdata[4:0];
        else if (apbWrite && paddr == ADDR_WAKE_EN)
            wakeEn_q <= pwdata[NUM_SRC-1:0];
    end

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_sleep_flags: assert property (sleepTake |=> !powerDownFlagN_q && timeOutFlagN_q)
        else $error("sleep entry did not update flags");
    a_osc_off: assert property (state_q == ST_SLEEP |-> !oscDriverEn_q)
        else $error("oscillator driver on during sleep");
    a_io_hold: assert property (state_q == ST_SLEEP |-> ioHold_q && coreHold_q)
        else $error("ports not held during sleep");
    a_wdt_entry_clear: assert property (sleepTake && wdtEnable |=> wdtCnt_q == 17'h00000)
        else $error("watchdog not cleared at sleep");
    a_nop_sleep: assert property (sleepNopNow |=> state_q == ST_RUN
                                  && $stable(powerDownFlagN_q) && sleepNop_q)
        else $error("pending irq did not make sleep a no-op");
    a_wake_clear: assert property (state_q == ST_SLEEP && wakeReq && !resetActive
                                   |=> state_q == ST_WAKE && wdtCnt_q == 17'h00000)
        else $error("wake did not clear watchdog");
    a_wdt_wake_flag: assert property (state_q == ST_SLEEP && wdtExpire && !resetActive
                                      |=> !timeOutFlagN_q && !powerDownFlagN_q)
        else $error("watchdog wake flags wrong");
    a_hold_until_ok: assert property (state_q == ST_WAKE && !oscOk && !resetActive
                                      |=> coreHold_q [*2])
        else $error("core released before clock valid");
    a_pin_reset: assert property (state_q == ST_SLEEP && resetActive
                                  |=> state_q == ST_RUN ##1 fullResetReq_q)
        else $error("reset pin wake not a full reset");
    a_prefetch: assert property (sleepTake |=> prefetchNext_q ##1 !prefetchNext_q)
        else $error("no prefetch on sleep");
    a_vector_pick: assert property (state_q == ST_SLEEP && irqWake && !wdtExpire && !resetActive
                                    |=> vectorAfterNext_q == $past(globalIrqEnable))
        else $error("vector choice wrong after irq wake");
endmodule

// *** testbench/swc_partner.sv ***
// partner model: core sleep sequence and main oscillator start-up
// assumes the controller's clk_sys and rst; changes outputs at rising edges
`timescale 1ns/1ps
module swc_partner
#(
    parameter int OscDelay = 20
)
(
    input wire logic clk_sys, // system clock
    input wire logic rst, // reset, high
    input wire logic sleepReq, // bench asks for a sleep sequence
    input wire logic oscDriverEn_q, // driver control from block
    output logic watchdogClearOp, // clear op pulse
    output logic sleepOp, // sleep op pulse
    output logic oscValid // oscillator stable
);
    int oscCnt;
    ////////////////////////////////////////////////////////////////////////////////
    // core: watchdog clear, then sleep on the next cycle
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            watchdogClearOp <= 1'b0;
            sleepOp <= 1'b0;
        end
        else
        begin
            watchdogClearOp <= sleepReq;
            sleepOp <= watchdogClearOp;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // oscillator: stable only some cycles after the driver turns on
    always_ff @(posedge clk_sys)
    begin
        if (rst || !oscDriverEn_q)
            oscCnt <= 0;
        else if (oscCnt < OscDelay)
            oscCnt <= oscCnt + 1;
    end
    assign oscValid = (oscCnt == OscDelay);
endmodule

// *** testbench/swc_sleep_wake_control_tb.sv ***
// self-checking bench for the sleep and wake controller
// assumes swc_partner as core and oscillator; apb tasks for the registers
`timescale 1ns/1ps
module swc_sleep_wake_control_tb;
    import swc_pkg::*;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic sleepReq, sleepOp, watchdogClearOp, globalIrqEnable, watchdogFuseEnable;
    logic [NUM_SRC-1:0] srcFlags;
    logic clockedIrqPending, externalResetPinN, externalIrqPin, oscValid;
    logic oscDriverEn_q, ioHold_q, coreHold_q, prefetchNext_q, sleepNop_q, resumeNext_q;
    logic vectorAfterNext_q, wdtResetReq_q, fullResetReq_q, powerDownFlagN_q, timeOutFlagN_q;
    logic wdtInSleep = 1'b0;
    int failCount, checks, n;

    swc_sleep_wake_control #(.WdtTickCycles(2)) dut (.clk_sys, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sleepOp, .watchdogClearOp,
        .globalIrqEnable, .watchdogFuseEnable, .srcFlags, .clockedIrqPending,
        .externalResetPinN, .externalIrqPin, .oscValid, .oscDriverEn_q, .ioHold_q,
        .coreHold_q, .prefetchNext_q, .sleepNop_q, .resumeNext_q, .vectorAfterNext_q,
        .wdtResetReq_q, .fullResetReq_q, .powerDownFlagN_q, .timeOutFlagN_q);
    swc_partner partner (.clk_sys, .rst, .sleepReq, .oscDriverEn_q, .watchdogClearOp,
        .sleepOp, .oscValid);

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (wdtResetReq_q === 1'b1 && coreHold_q === 1'b1)
            wdtInSleep <= 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return pready;
            1: return resumeNext_q;
            2: return wdtResetReq_q;
            3: return fullResetReq_q;
            default: return oscDriverEn_q;
        endcase
    endfunction
    // polls at rising edges; returns at the edge where the signal is seen high
    task automatic wait_hi(input int k, input int lim);
        n = 0;
        while (pick(k) !== 1'b1)
        begin
            @(posedge clk_sys);
            n++;
            if (n > lim)
            begin
                failCount++;
                $display("ERROR at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
                close_out();
            end
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        wait_hi(0, 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
        check(32'(rerr), 32'(expErr));
    endtask
    task automatic do_sleep();
        @(posedge clk_sys);
        sleepReq <= 1'b1;
        @(posedge clk_sys);
        sleepReq <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic apply_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, psel, penable, pwrite, sleepReq, globalIrqEnable} = 6'h21;
        {watchdogFuseEnable, clockedIrqPending, externalIrqPin} = 3'h0;
        externalResetPinN = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        srcFlags = 9'h000;
        failCount = 0;
        checks = 0;
        apply_reset();
        check(32'({oscDriverEn_q, ioHold_q, coreHold_q, powerDownFlagN_q, timeOutFlagN_q}),
            32'h13);
        rd(ADDR_CTRL, 32'h8, 1'b0);
        rd(ADDR_WAKE_EN, 32'h0, 1'b0);
        apb(1'b1, ADDR_STATUS, 32'h0);
        rd(ADDR_STATUS, 32'h3, 1'b0);
        rd(8'h10, 32'h0, 1'b1);
        $display("registers done");
        for (int k = 0; k < NUM_SRC; k++)
        begin
            apb(1'b1, ADDR_WAKE_EN, 32'h1 << k);
            do_sleep();
            check(32'(prefetchNext_q), 32'h1);
            check(32'({oscDriverEn_q, ioHold_q, coreHold_q, powerDownFlagN_q, timeOutFlagN_q}),
                32'h0D);
            srcFlags <= 9'h1 << ((k + 1) % NUM_SRC);
            globalIrqEnable <= k[0];
            repeat (6) @(posedge clk_sys);
            check(32'({coreHold_q, oscDriverEn_q}), 32'h2);
            srcFlags <= (k == SRC_EXT_PIN ? 9'h000 : 9'h1 << k) | (9'h1 << ((k + 1) % NUM_SRC));
            externalIrqPin <= k == SRC_EXT_PIN;
            wait_hi(1, 300);
            check(32'({vectorAfterNext_q, coreHold_q, ioHold_q, oscDriverEn_q}),
                32'({k[0], 3'h1}));
            srcFlags <= 9'h000;
            externalIrqPin <= 1'b0;
        end
        $display("interrupt wakes done");
        apb(1'b1, ADDR_WAKE_EN, 32'h8);
        srcFlags <= 9'h008;
        do_sleep();
        check(32'({sleepNop_q, prefetchNext_q, oscDriverEn_q, powerDownFlagN_q}), 32'hF);
        rd(ADDR_FLAGS, 32'h8, 1'b0);
        srcFlags <= 9'h000;
        clockedIrqPending <= 1'b1;
        do_sleep();
        check(32'({sleepNop_q, oscDriverEn_q, coreHold_q}), 32'h6);
        clockedIrqPending <= 1'b0;
        $display("no-op sleeps done");
        do_sleep();
        externalResetPinN <= 1'b0;
        wait_hi(3, 20);
        check(32'({powerDownFlagN_q, wdtResetReq_q}), 32'h0);
        check(32'({oscDriverEn_q, ioHold_q, coreHold_q}), 32'h4);
        repeat (4) @(posedge clk_sys);
        externalResetPinN <= 1'b1;
        wait_hi(4, 20);
        apply_reset();
        rd(ADDR_STATUS, 32'h3, 1'b0);
        $display("reset pin wake done");
        apb(1'b1, ADDR_CTRL, 32'h1);
        rd(ADDR_STATUS, 32'h7, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        watchdogFuseEnable <= 1'b1;
        wait_hi(2, 200);
        @(posedge clk_sys);
        check(32'({fullResetReq_q, powerDownFlagN_q, timeOutFlagN_q}), 32'h2);
        wait_hi(2, 200);
        check(32'(n >= 60 && n <= 68), 32'h1);
        do_sleep();
        check(32'({powerDownFlagN_q, timeOutFlagN_q, coreHold_q}), 32'h3);
        wait_hi(1, 300);
        check(32'({powerDownFlagN_q, timeOutFlagN_q, vectorAfterNext_q, wdtInSleep}),
            32'h0);
        watchdogFuseEnable <= 1'b0;
        $display("watchdog done");
        close_out();
    end
endmodule
